//--- ipl_assertions.sv
/* port checker for the priority slice; bound from the bench top */
`timescale 1ns/1ps
module ipl_assertions
import ipl_pkg::*;
(input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [5:0] paddr, input wire logic [31:0] pwdata, prdata,
   input wire logic [19:0] irq_req, input ipl_irq_t irq_out);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   wire [3:0] ix = paddr[5:2];
   wire [6:0] slot = irq_out.vector_address_bus[6:0];
   rdy_a: assert property (pready) else $error("ready low");
   lvl_cap_a: assert property (irq_out.valid |-> irq_out.level != 2'h3)
      else $error("level too high");
   rst_idle_a: assert property ($rose(presetn) |-> !irq_out.valid)
      else $error("valid after reset");
   gate_a: assert property (irq_out.valid |-> $past(irq_req) != 20'h0)
      else $error("no request behind valid");
   vec_a: assert property (irq_out.valid |-> slot inside {[7'h10:7'h23]})
      else $error("slot out of range");
   refuse_a: assert property (acc && !(ix inside {4'h2, 4'h3, 4'h4, 4'h7})
      |-> pslverr && prdata == 32'h0) else $error("unmapped answered");
   reg2_a: assert property (acc && !pwrite && ix == 4'h2
      |-> prdata[31:8] == 24'h0) else $error("reg2 high bits");
   reg34_a: assert property (acc && !pwrite && ix inside {4'h3, 4'h4}
      |-> prdata[31:16] == 16'h0) else $error("reg3/4 high bits");
endmodule : ipl_assertions

//--- ipl_periph.sv
/* request-line model; assumes the bench drives want off the edge */
`timescale 1ns/1ps
module ipl_periph (input wire logic pclk, input wire logic [19:0] want,
   output logic [19:0] irq_req);
   // flopped so lines move just after an edge, as a real peripheral would
   always_ff @(posedge pclk) irq_req <= want;
endmodule : ipl_periph

//--- ipl_pkg.sv
/*
 Constants, field layout and types for the interrupt priority-level slice.
 Assumes an APB master with 32-bit data; registers sit one per word.
*/
// Functional notes
// - field 00 disables, 01 gives level 0, 10 level 1, 11 level 2.
// - no source in this slice can reach a level above 2.
// - every priority field resets to zero, so all sources start disabled.
// - reg 3 upper byte: twowire error, serial1 rx full, rx error, tx idle.
// - reg 3 lower byte: serial1 tx empty, serial0 rx full, rx error, tx idle.
// - reg 4 upper byte: timer A channels 3, 2, 1, 0 from the top.
// - reg 4 lower byte: twowire status, transmit, receive, general call.
// - reg 2 lower byte: spi0 rx full, port A, port B, port C.
// - low 7 vector bits come from the winning source, appended to the base.
package ipl_pkg;
   localparam int IPL_NSRC = 20;
   localparam int IPL_FW = 2;
   // printed offsets are word indices; byte address is four times index
   localparam logic [3:0] IPL_IDX_REG2 = 4'h2;
   localparam logic [3:0] IPL_IDX_REG3 = 4'h3;
   localparam logic [3:0] IPL_IDX_REG4 = 4'h4;
   localparam logic [3:0] IPL_IDX_VBASE = 4'h7;
   localparam logic [7:0] IPL_REG2_RST = 8'h00;
   localparam logic [15:0] IPL_REG3_RST = 16'h0000;
   localparam logic [15:0] IPL_REG4_RST = 16'h0000;
   localparam logic [13:0] IPL_VBASE_RST = 14'h0000;
   localparam int IPL_VBASE_W = 14;
   localparam int IPL_VLOW_W = 7;
   localparam logic [1:0] IPL_FLD_OFF = 2'h0;
   // vector slot of source 0; source i uses slot base + i
   localparam logic [6:0] IPL_VEC_FIRST = 7'h10;
   // source index is the field slot, counted from bit 0 upward:
   // sources 0-3: reg2 bits 1-0..7-6, 4-11: reg3 bits 1-0..15-14,
   // 12-19: reg4 bits 1-0..15-14
   typedef struct packed {
      logic valid;
      logic [1:0] level;
      logic [20:0] vector_address_bus;
   } ipl_irq_t;
endpackage : ipl_pkg

//--- ipl_prio_regs.sv
/*
 Priority-level register slice with request arbitration and vector output.
 Assumes synchronous APB, active-level peripheral requests, one clock.
*/
`timescale 1ns/1ps
module ipl_prio_regs
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [5:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [19:0] irq_req,
   output ipl_pkg::ipl_irq_t irq_out
);
   import ipl_pkg::*;

   logic [7:0] reg2_ff;
   logic [15:0] reg3_ff;
   logic [15:0] reg4_ff;
   logic [IPL_VBASE_W-1:0] vbase_ff;
   ipl_irq_t irq_ff;
   ipl_irq_t nxt_irq;

   wire [3:0] idx = paddr[5:2];
   wire wr_en = psel && penable && pwrite;
   wire hit2 = (idx == IPL_IDX_REG2);
   wire hit3 = (idx == IPL_IDX_REG3);
   wire hit4 = (idx == IPL_IDX_REG4);
   wire hitv = (idx == IPL_IDX_VBASE);
   wire mapped = hit2 || hit3 || hit4 || hitv;
   wire [39:0] fields = {reg4_ff, reg3_ff, reg2_ff};

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = hit2 ? {24'h000000, reg2_ff} :
                   hit3 ? {16'h0000, reg3_ff} :
                   hit4 ? {16'h0000, reg4_ff} :
                   hitv ? {18'h00000, vbase_ff} : 32'h00000000;
   assign irq_out = irq_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reg2_ff <= IPL_REG2_RST;
         reg3_ff <= IPL_REG3_RST;
         reg4_ff <= IPL_REG4_RST;
         vbase_ff <= IPL_VBASE_RST;
      end
      else if (wr_en)
      begin
         if (hit2)
            reg2_ff <= pwdata[7:0];
         if (hit3)
            reg3_ff <= pwdata[15:0];
         if (hit4)
            reg4_ff <= pwdata[15:0];
         if (hitv)
            vbase_ff <= pwdata[IPL_VBASE_W-1:0];
      end
   end

   // per-source effective level: 0 disabled, else encoded level plus one
   logic [1:0] eff [IPL_NSRC];
   genvar g;
   generate
      for (g = 0; g < IPL_NSRC; g++)
      begin : g_src
         wire [1:0] fld = fields[2*g+1:2*g];
         // field 00 masks the request; 11 tops out at level 2
         assign eff[g] = irq_req[g] ? fld : IPL_FLD_OFF;
      end
   endgenerate

   // lowest source index wins ties, since only a strictly higher level
   // displaces the current pick while scanning upward
   always_comb
   begin
      logic [1:0] best;
      logic [4:0] win;
      best = IPL_FLD_OFF;
      win = 5'h00;
      for (int i = 0; i < IPL_NSRC; i++)
      begin
         if (eff[i] > best)
         begin
            best = eff[i];
            win = 5'(i);
         end
      end
      nxt_irq.valid = (best != IPL_FLD_OFF);
      nxt_irq.level = best - 2'h1;
      nxt_irq.vector_address_bus = {vbase_ff,
         IPL_VEC_FIRST + {2'h0, win}};
      if (best == IPL_FLD_OFF)
         nxt_irq.level = 2'h0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_ff <= '0;
      else
         irq_ff <= nxt_irq;
   end
endmodule : ipl_prio_regs

//--- testbench.sv
/* apb bench with queued expectations; needs package, design, model */
`timescale 1ns/1ps
module testbench;
   import ipl_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, look = 0;
   logic err = 0;
   logic pready, pslverr;
   logic [5:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, w, q[$];
   logic [19:0] want = 20'h30, irq_req;
   // valid, level, base 1abc, slot 10h plus winning source
   logic [23:0] ex[6] = '{0, 24'h8d5e14, 24'had5e14, 24'hcd5e14, 24'hcd5e15,
      24'hcd5e14};
   ipl_irq_t irq_out;
   int bad_count = 0, cmp_count = 0, cyc = 0;
   always #12.5 pclk = ~pclk;
   ipl_periph u_per (.pclk, .want, .irq_req);
   ipl_prio_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq_req, .irq_out);
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : bus
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      bad_count += (s !== e);
      if (s !== e) $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
   endtask : chk
   // fields behind a clear valid are left open, so they are masked
   always @(posedge pclk) if (look || psel && penable && pready && !pwrite)
      chk(look ? (irq_out.valid ? 32'(irq_out) : 32'h0) : prdata,
         q.pop_front());
   always @(posedge pclk) if (++cyc == 3000) give_verdict(1);
   task give_verdict(input int late);
      bad_count += late;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      w = $urandom(32'h594e);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 2; i < 8; i++)
      begin
         q.push_back(32'h0);
         bus(1'b0, 6'(i * 4), 32'h0);
         chk(32'(err), 32'(i == 5 || i == 6));
      end
      $display("reset value test done");
      for (int i = 2; i < 5; i++)
      begin
         w = $urandom;
         bus(1'b1, 6'(i * 4), w);
         q.push_back(w & (i == 2 ? 32'hff : 32'hffff));
         bus(1'b0, 6'(i * 4), 32'h0);
      end
      $display("field layout test done");
      bus(1'b1, 6'h1c, 32'h1abc);
      foreach (ex[k])
      begin
         // codes 0..3 on source 4, then 0dh and 0fh pit source 5 against it
         bus(1'b1, 6'h0c, 32'(k < 4 ? k : k * 2 + 5));
         repeat (2) @(posedge pclk);
         q.push_back(32'(ex[k]));
         look <= 1'b1;
         @(posedge pclk) look <= 1'b0;
      end
      $display("level and arbitration test done");
      give_verdict(0);
   end
endmodule : testbench
bind ipl_prio_regs ipl_assertions u_chk (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .irq_req, .irq_out);
